//--- rfl_regs.vh
// Register offsets, field positions and timing counts of the regulator fault latches
`ifndef RFL_REGS_VH
`define RFL_REGS_VH
`define RFL_ADDR_RESET_CTRL   8'h18
`define RFL_ADDR_RESET_EVENT  8'h1a
`define RFL_ADDR_CONV_EVENT   8'h1b
`define RFL_ADDR_LINREG_EVENT 8'h1c
`define RFL_ADDR_TOP_SUMMARY  8'h19
`define RFL_BIT_RESET_EVENT   0
`define RFL_BIT_SOFTWARE_RESET_REQUEST      0
`define RFL_BIT_CONV_SUMMARY  5
`define RFL_BIT_LINREG_SUMMARY 6
`define RFL_FLAG_MASK         8'h77
`define RFL_RESET_VALUE       8'h00
`define RFL_CLK_MHZ           250
`define RFL_SHORT_TIME_US     1000
// Clock cycles in the short time at the nominal clock, sized for the 18-bit timer
`define RFL_SHORT_CYCLES      18'd250000
`define RFL_SHORT_CNT_W       18
`endif

//--- rfl_short_timer.v
// Short-circuit qualification timer for one regulator output
`timescale 1ns/1ps
`include "rfl_regs.vh"
module rfl_short_timer #(
   parameter [17:0] SHORT_CYCLES = `RFL_SHORT_CYCLES
) (
   // Clock and reset
   input  wire clk,
   input  wire nrst,
   input  wire clear,
   // Comparator in, qualified event out
   input  wire below_thresh,
   output reg  short_event
);
   reg [17:0] count;

   // Counts unbroken low time; any high sample restarts the count
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count       <= 18'h00000;
         short_event <= 1'b0;
      end else if (clear || !below_thresh) begin
         count       <= 18'h00000;
         short_event <= 1'b0;
      end else begin
         if (count != SHORT_CYCLES)
            count <= count + 18'h00001;
         // Fires once the low time strictly exceeds the limit
         short_event <= (count == SHORT_CYCLES);
      end
   end
endmodule

//--- rfl_latches.v
// Sticky event latches for supply reset, converters and linear regulators
// Operation
// R1 - Undervoltage or software reset sets reset flag
// R2 - Reset event clears registers, runs startup
// R3 - Reset flag stays until host writes 1
// R4 - Converter flags at 0x1B, bits 6:4, 2:0
// R5 - Linear regulator flags at 0x1C, same layout
// R6 - Short flag after over 1 ms low
// R7 - Current limit and power-good events set flags
// R8 - Each flag clears only by writing 1; a reset event also returns the event flags to their default
// R9 - Converter summary bit follows converter flags
// R10 - Linear summary bit follows linear flags
// R11 - Software reset bit self-clears after reset
// R12 - Set beats simultaneous host clear
//
// Register map seen through the register port
//   0x18 bit 0   software reset request, write only, reads as zero
//   0x19 bit 6   linear regulator summary, read only
//   0x19 bit 5   converter summary, read only
//   0x1a bit 0   reset event flag, write 1 to clear
//   0x1b         converter event flags, write 1 to clear per bit
//   0x1c         linear regulator event flags, write 1 to clear per bit
// Flag bit layout in 0x1b and 0x1c
//   bit 6 power good, bit 5 short, bit 4 current limit of unit 1
//   bit 2 power good, bit 1 short, bit 0 current limit of unit 0
//   bits 7 and 3 are reserved, never set and read as zero
//
// Timing notes
//   A clear write takes effect in the flags at the edge that samples it.
//   Summary bits are computed from the next flag values, so they never
//   lag the flag registers; a read of 0x19 always agrees with 0x1b/0x1c.
//   The short timer needs an unbroken low spell; one high sample restarts it.
//   While a reset cause lasts, the event flags are held at their default and
//   the reset flag is held set, so a host clear in that time has no effect.
`timescale 1ns/1ps
`include "rfl_regs.vh"
module rfl_latches #(
   parameter [17:0] SHORT_CYCLES = `RFL_SHORT_CYCLES
) (
   // Clock and reset
   input  wire       clk,
   input  wire       nrst,
   // Register port from the serial interface
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   // Analog monitors: index 0,1 converters, 2,3 linear regulators
   input  wire       analog_supply_uv,
   input  wire [3:0] power_good_event,
   input  wire [3:0] below_short_thresh,
   input  wire [3:0] current_limit_active,
   // Reset and startup control and summary bits toward the rest of the device
   output reg        regulators_disable,
   output reg        register_reset,
   output reg        startup_start,
   output reg        conv_summary,
   output reg        linreg_summary
);
   reg        reset_event;
   reg [7:0]  conv_flags;
   reg [7:0]  linreg_flags;
   reg        software_reset_request_pend;
   wire [3:0] short_evt;
   wire [7:0] conv_set;
   wire [7:0] linreg_set;
   wire [7:0] conv_clr;
   wire [7:0] linreg_clr;
   wire       rst_clr;
   wire       reset_trigger;
   wire       wr_software_reset_request;
   // Next values of the flags and of the read data
   reg        next_reset_event;
   reg  [7:0] next_conv_flags;
   reg  [7:0] next_linreg_flags;
   reg  [7:0] next_rdata;

   // R6 one timer per regulator
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_short
         rfl_short_timer #(
            .SHORT_CYCLES (SHORT_CYCLES)
         ) u_timer (
            .clk          (clk),
            .nrst         (nrst),
            .clear        (reset_trigger),
            .below_thresh (below_short_thresh[g]),
            .short_event  (short_evt[g])
         );
      end
   endgenerate

   // R4 converter layout: pg, short, ilim
   assign conv_set   = {1'b0, power_good_event[1], short_evt[1], current_limit_active[1],
                        1'b0, power_good_event[0], short_evt[0], current_limit_active[0]};
   // R5 linear regulator layout
   assign linreg_set = {1'b0, power_good_event[3], short_evt[3], current_limit_active[3],
                        1'b0, power_good_event[2], short_evt[2], current_limit_active[2]};

   // R8 write-one clears per bit
   assign conv_clr   = (reg_wr && reg_addr == `RFL_ADDR_CONV_EVENT) ?
                       (reg_wdata & `RFL_FLAG_MASK) : 8'h00;
   assign linreg_clr = (reg_wr && reg_addr == `RFL_ADDR_LINREG_EVENT) ?
                       (reg_wdata & `RFL_FLAG_MASK) : 8'h00;
   // R3 write one clears reset flag
   assign rst_clr    = reg_wr && reg_addr == `RFL_ADDR_RESET_EVENT &&
                       reg_wdata[`RFL_BIT_RESET_EVENT];
   assign wr_software_reset_request = reg_wr && reg_addr == `RFL_ADDR_RESET_CTRL &&
                        reg_wdata[`RFL_BIT_SOFTWARE_RESET_REQUEST];
   // R1 reset sources
   assign reset_trigger = analog_supply_uv || software_reset_request_pend;

   // R12 set terms are ORed after the clear, so a host clear never drops an event
   always @* begin
      // R3 write one clears the reset flag
      next_reset_event  = reset_event & ~rst_clr;
      // R7 events latch; R8 cleared bits drop
      next_conv_flags   = (conv_flags & ~conv_clr) | conv_set;
      next_linreg_flags = (linreg_flags & ~linreg_clr) | linreg_set;
      // R1 a reset cause overrides any host clear
      if (reset_trigger) begin
         next_reset_event  = 1'b1;
         // R2 event registers return to their default
         next_conv_flags   = `RFL_RESET_VALUE;
         next_linreg_flags = `RFL_RESET_VALUE;
      end
   end

   // R2 reset event wipes flags, requests startup; reset flag kept set
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reset_event        <= 1'b0;
         conv_flags         <= `RFL_RESET_VALUE;
         linreg_flags       <= `RFL_RESET_VALUE;
         software_reset_request_pend      <= 1'b0;
         regulators_disable <= 1'b0;
         register_reset     <= 1'b0;
         startup_start      <= 1'b0;
      end else begin
         regulators_disable <= reset_trigger;
         register_reset     <= reset_trigger;
         // Startup follows once the reset cause has gone away
         startup_start      <= regulators_disable && !reset_trigger;
         // R11 request bit self-clears after one cycle
         software_reset_request_pend      <= wr_software_reset_request;
         reset_event        <= next_reset_event;
         conv_flags         <= next_conv_flags;
         linreg_flags       <= next_linreg_flags;
      end
   end

   // R9 R10 summaries from next flags, so they never trail the registers
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         conv_summary   <= 1'b0;
         linreg_summary <= 1'b0;
      end else begin
         conv_summary   <= |next_conv_flags;
         linreg_summary <= |next_linreg_flags;
      end
   end

   // Read mux; reserved bits and unmapped addresses read as zero
   always @* begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         case (reg_addr)
            `RFL_ADDR_RESET_EVENT: begin
               next_rdata = {7'h00, reset_event};
            end
            `RFL_ADDR_CONV_EVENT: begin
               next_rdata = conv_flags;
            end
            `RFL_ADDR_LINREG_EVENT: begin
               next_rdata = linreg_flags;
            end
            // R9 R10 summary bits in the top register
            `RFL_ADDR_TOP_SUMMARY: begin
               next_rdata = {1'b0, linreg_summary, conv_summary, 5'h00};
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   // Read data holds between reads so the host may sample it late
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule

//--- rfl_chk_assertions.sv
// Port checker of the regulator fault latches
`timescale 1ns/1ps
module rfl_chk (
   // Watched ports
   input wire       clk,
   input wire       nrst,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_rdata,
   input wire       analog_supply_uv,
   input wire [3:0] current_limit_active,
   input wire       regulators_disable,
   input wire       register_reset,
   input wire       startup_start,
   input wire       conv_summary,
   input wire       linreg_summary
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Quiet cycle: no undervoltage, regulators enabled, no write
   sequence s_q; !analog_supply_uv && !regulators_disable && !reg_wr; endsequence
   sequence s_end; regulators_disable ##1 !regulators_disable; endsequence
   property p_dis; analog_supply_uv |=> regulators_disable; endproperty
   a_dis: assert property (p_dis) else $error("disable late");
   property p_rr; regulators_disable |-> register_reset; endproperty
   a_rr: assert property (p_rr) else $error("no register reset");
   property p_st; s_end |-> startup_start; endproperty
   a_st: assert property (p_st) else $error("no startup");
   property p_stp; startup_start |=> !startup_start; endproperty
   a_stp: assert property (p_stp) else $error("startup long");
   property p_cs; (current_limit_active[0] ##0 s_q) |-> ##1 conv_summary; endproperty
   a_cs: assert property (p_cs) else $error("conv summary");
   property p_ls; (current_limit_active[2] ##0 s_q) |-> ##1 linreg_summary; endproperty
   a_ls: assert property (p_ls) else $error("linreg summary");
   property p_top; reg_rd && reg_addr == 8'h19 |=>
      reg_rdata == {1'b0, $past(linreg_summary), $past(conv_summary), 5'h00}; endproperty
   a_top: assert property (p_top) else $error("summary read");
   property p_rsv; reg_rd && reg_addr[7:1] == 7'h0e |=> !reg_rdata[7] && !reg_rdata[3];
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
endmodule
bind rfl_latches rfl_chk u_chk (.*);

//--- rfl_host.sv
// Host model on the register port of the latches
`timescale 1ns/1ps
module rfl_host (
   // Register port
   input  wire       clk,
   input  wire [7:0] reg_rdata,
   output reg        reg_wr,
   output reg        reg_rd,
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata
);
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
   task wr(input [7:0] a, input [7:0] d);
      @(negedge clk); reg_wr = 1; reg_addr = a; reg_wdata = d;
      @(negedge clk); reg_wr = 0;
   endtask
   // Data is registered one edge after the strobe
   task rd(input [7:0] a, output [7:0] d);
      @(negedge clk); reg_rd = 1; reg_addr = a;
      @(negedge clk); reg_rd = 0; d = reg_rdata;
   endtask
endmodule

//--- rfl_latches_tb.sv
// Self-checking bench of the regulator fault latches
`timescale 1ns/1ps
module rfl_latches_tb;
   reg        clk = 0, nrst = 0, uv = 0;
   reg  [3:0] pg = 0, bl = 0, cl = 0;
   reg  [7:0] v;
   wire       wr, rd, dis, rr, ss, cs, ls;
   wire [7:0] addr, wd, rdt;
   integer    error_cnt = 0, checks = 0;
   initial forever #2 clk = ~clk;
   rfl_host u_host (.clk(clk), .reg_rdata(rdt), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
      .reg_wdata(wd));
   // Short count cut to 20 cycles to keep the run brief
   rfl_latches #(.SHORT_CYCLES(18'd20)) u_dut (.clk(clk), .nrst(nrst), .reg_wr(wr),
      .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdt), .analog_supply_uv(uv),
      .power_good_event(pg), .below_short_thresh(bl), .current_limit_active(cl),
      .regulators_disable(dis), .register_reset(rr), .startup_start(ss),
      .conv_summary(cs), .linreg_summary(ls));
   task test_done;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Read a register and compare
   task chk(input [7:0] a, input [7:0] e);
      u_host.rd(a, v);
      checks = checks + 1;
      if (v !== e) begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH %0t got %h exp %h", $time, v, e);
      end
   endtask
   // Compare a sampled output value
   task chk_sig(input [7:0] g, input [7:0] e);
      checks = checks + 1;
      if (g !== e) begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task cyc(input integer n); repeat (n) @(negedge clk); endtask
   task t_reset_vals;
      chk(8'h1a, 8'h00); chk(8'h1b, 8'h00); chk(8'h1c, 8'h00);
   endtask
   // Broken low spell of 15 must not count, 26 must
   task t_events;
      cyc(1); cl = 4'hf; pg = 4'hf; cyc(1); cl = 0; pg = 0; bl = 4'hf; cyc(15); bl = 0;
      cyc(1); bl = 4'h5; cyc(26); bl = 0;
      chk(8'h1b, 8'h57); chk(8'h1c, 8'h57);
      chk(8'h19, 8'h60);
      chk_sig({6'h00, ls, cs}, 8'h03);
   endtask
   task t_clear;
      u_host.wr(8'h1b, 8'h0e); chk(8'h1b, 8'h51);
      u_host.wr(8'h1b, 8'hff); u_host.wr(8'h1c, 8'h10); chk(8'h19, 8'h40);
      chk(8'h1c, 8'h47); u_host.wr(8'h1c, 8'hff); chk(8'h19, 8'h00);
      fork
         u_host.wr(8'h1b, 8'h01);
         begin cyc(1); cl = 4'h1; cyc(1); cl = 0; end
      join
      chk(8'h1b, 8'h01);
   endtask
   task t_rst_event;
      uv = 1; cyc(2);
      chk_sig({5'h00, dis, rr, ss}, 8'h06);
      uv = 0; cyc(1);
      chk_sig({5'h00, dis, rr, ss}, 8'h01);
      cyc(4);
      chk(8'h1a, 8'h01); chk(8'h1b, 8'h00);
      u_host.wr(8'h1a, 8'hff); chk(8'h1a, 8'h00);
      cl = 4'h4; cyc(1); cl = 0; u_host.wr(8'h18, 8'h01); cyc(4);
      chk(8'h1a, 8'h01); chk(8'h1c, 8'h00); chk(8'h18, 8'h00);
   endtask
   initial begin
      cyc(4); nrst = 1;
      t_reset_vals; t_events; t_clear; t_rst_event;
      test_done;
   end
   // Watchdog: the tests need under 300 cycles
   initial begin
      #4000;
      error_cnt = error_cnt + 1;
      test_done;
   end
endmodule
